/* File: rtl/hfp_top.sv */
/*
 Host FIFO port block: receive status, receive data, transmit status
 and transmit data queues behind an SRAM-like single-cycle host port,
 plus attribute bits and a configuration word.
 Assumes the MAC side feeds and drains the queues on this same clock,
 and that host reads and writes are one-cycle strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module hfp_top
    import hfp_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_soft_rst,
    // Host port
    input wire logic i_host_rd,
    input wire logic i_host_wr,
    input wire logic [HFP_AW-1:0] i_host_addr,
    input wire logic [HFP_DW-1:0] i_host_wdata,
    output logic [HFP_DW-1:0] o_host_rdata,
    output logic o_host_ack,
    // MAC receive side
    input wire logic i_rxs_valid,
    input wire logic [HFP_DW-1:0] i_rxs_data,
    output logic o_rxs_ready,
    input wire logic i_rxd_valid,
    input wire logic [HFP_DW-1:0] i_rxd_data,
    output logic o_rxd_ready,
    // MAC transmit side
    input wire logic i_txs_valid,
    input wire logic [HFP_DW-1:0] i_txs_data,
    output logic o_txs_ready,
    output logic o_txd_valid,
    output logic [HFP_DW-1:0] o_txd_data,
    input wire logic i_txd_ready,
    // Status events
    input wire logic [1:0] i_w1c_evt,
    input wire logic [1:0] i_rc_evt,
    input wire logic i_hi_cond,
    input wire logic i_lo_cond,
    // Configuration out
    output logic [7:0] o_exempt_cfg
);
    localparam int NQ = 4;
    localparam int QRS = 0;
    localparam int QRD = 1;
    localparam int QTS = 2;
    localparam int QTD = 3;

    logic [NQ-1:0] in_valid;
    logic [HFP_DW-1:0] in_data [NQ];
    logic [NQ-1:0] in_ready;
    logic [NQ-1:0] out_valid;
    logic [HFP_DW-1:0] out_data [NQ];
    logic [NQ-1:0] out_ready;
    logic [HFP_QPW-1:0] count [NQ];
    logic [HFP_QPW-1:0] limit [NQ];
    logic [HFP_LIM_W-1:0] lim_rs_r;
    logic [HFP_LIM_W-1:0] lim_rd_r;
    logic [HFP_LIM_W-1:0] lim_td_r;
    logic [7:0] exempt_r;
    logic [HFP_DW-1:0] rdata_nxt;
    logic [HFP_DW-1:0] rdata_r;
    logic ack_r;
    logic [1:0] alias_tag;
    logic hit_rxd;
    logic hit_txd;
    logic rd_rs_pop;
    logic rd_ts_pop;
    logic rd_rxd;
    logic wr_txd;
    logic wr_cfg;
    logic wr_clr;
    logic rd_sts;
    logic rd_lat;
    logic [1:0] w1c_bits;
    logic [1:0] rc_bits;
    logic lh_bit;
    logic ll_bit;
    logic [HFP_DW-1:0] txd_out_r;
    logic txd_vld_r;

    // Alias decode: the upper address bits pick a 16-word window
    assign alias_tag = i_host_addr[HFP_AW-1:HFP_ALIAS_SHIFT];
    assign hit_rxd = (alias_tag == HFP_RXD_TAG);
    assign hit_txd = (alias_tag == HFP_TXD_TAG);
    assign rd_rxd = i_host_rd && hit_rxd;
    assign rd_rs_pop = i_host_rd && (i_host_addr == HFP_RXS_POP);
    assign rd_ts_pop = i_host_rd && (i_host_addr == HFP_TXS_POP);
    // Of the four queues, writes only ever reach the transmit data queue
    assign wr_txd = i_host_wr && hit_txd;
    assign wr_cfg = i_host_wr && (i_host_addr == HFP_CFG_ADDR);
    assign wr_clr = i_host_wr && (i_host_addr == HFP_CLR_ADDR);
    assign rd_sts = i_host_rd && (i_host_addr == HFP_STS_ADDR);
    assign rd_lat = i_host_rd && (i_host_addr == HFP_LAT_ADDR);

    // Queue fill and drain hookup
    assign in_valid = {wr_txd, i_txs_valid, i_rxd_valid, i_rxs_valid};
    assign in_data[QRS] = i_rxs_data;
    assign in_data[QRD] = i_rxd_data;
    assign in_data[QTS] = i_txs_data;
    assign in_data[QTD] = i_host_wdata;
    // Peek ports raise no pop strobe
    assign out_ready[QRS] = rd_rs_pop;
    assign out_ready[QRD] = rd_rxd;
    assign out_ready[QTS] = rd_ts_pop;
    assign out_ready[QTD] = i_txd_ready || !txd_vld_r;
    assign limit[QRS] = lim_rs_r;
    assign limit[QRD] = lim_rd_r;
    assign limit[QTS] = HFP_QPW'(HFP_QDEPTH);
    assign limit[QTD] = lim_td_r;

    // One queue per port
    genvar q;
    generate
        for (q = 0; q < NQ; q++)
        begin : g_q
            hfp_fifo #(
                .WIDTH(HFP_DW),
                .DEPTH(HFP_QDEPTH)
            ) u_fifo (
                .i_sys_clk(i_sys_clk),
                .i_reset_n(i_reset_n),
                .i_flush(i_soft_rst),
                .i_limit(limit[q]),
                .i_in_valid(in_valid[q]),
                .i_in_data(in_data[q]),
                .o_in_ready(in_ready[q]),
                .o_out_valid(out_valid[q]),
                .o_out_data(out_data[q]),
                .i_out_ready(out_ready[q]),
                .o_count(count[q])
            );
        end
    endgenerate

    // Attribute bits
    hfp_attr_bits u_bits (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_soft_rst(i_soft_rst),
        .i_w1c_evt(i_w1c_evt),
        .i_rc_evt(i_rc_evt),
        .i_hi_cond(i_hi_cond),
        .i_lo_cond(i_lo_cond),
        .i_clr_wr(wr_clr),
        .i_clr_data(i_host_wdata[1:0]),
        .i_sts_rd(rd_sts),
        .i_lat_rd(rd_lat),
        .o_w1c(w1c_bits),
        .o_rc(rc_bits),
        .o_lh(lh_bit),
        .o_ll(ll_bit)
    );

    // Capacity config; defaults return on either reset
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n || i_soft_rst)
        begin
            lim_rs_r <= HFP_LIM_RST;
            lim_rd_r <= HFP_LIM_RST;
            lim_td_r <= HFP_LIM_RST;
        end
        else if (wr_cfg)
        begin
            lim_rs_r <= i_host_wdata[2:0];
            lim_rd_r <= i_host_wdata[6:4];
            lim_td_r <= i_host_wdata[10:8];
        end
    end

    // Exempt byte survives soft reset so it can carry straps or setup
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
            exempt_r <= HFP_EXEMPT_RST;
        else if (wr_cfg)
            exempt_r <= i_host_wdata[23:16];
    end

    // Read mux; write-only and data-in ports read zero, reserved bits zero
    always_comb
    begin
        rdata_nxt = HFP_ZERO;
        if (hit_rxd)
            rdata_nxt = out_valid[QRD] ? out_data[QRD] : HFP_ZERO;
        else
        begin
            unique case (i_host_addr)
                HFP_RXS_POP, HFP_RXS_PEEK:
                    rdata_nxt = out_valid[QRS] ? out_data[QRS] : HFP_ZERO;
                HFP_TXS_POP, HFP_TXS_PEEK:
                    rdata_nxt = out_valid[QTS] ? out_data[QTS] : HFP_ZERO;
                HFP_STS_ADDR:
                    rdata_nxt = {13'h0000, count[QTD], 1'b0, count[QTS],
                        1'b0, count[QRD], 1'b0, count[QRS], rc_bits, w1c_bits};
                HFP_CFG_ADDR:
                    rdata_nxt = {8'h00, exempt_r, 5'h00, lim_td_r, 1'b0, lim_rd_r,
                        1'b0, lim_rs_r};
                HFP_LAT_ADDR:
                    rdata_nxt = {30'h0000_0000, ll_bit, lh_bit};
                default:
                    rdata_nxt = HFP_ZERO;
            endcase
        end
    end

    // Registered read answer, one cycle after the strobe
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            rdata_r <= HFP_ZERO;
            ack_r <= 1'b0;
        end
        else
        begin
            rdata_r <= i_host_rd ? rdata_nxt : HFP_ZERO;
            ack_r <= i_host_rd || i_host_wr;
        end
    end

    // Transmit data output stage, so the port comes from a flop
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n || i_soft_rst)
        begin
            txd_vld_r <= 1'b0;
            txd_out_r <= HFP_ZERO;
        end
        else if (out_ready[QTD])
        begin
            txd_vld_r <= out_valid[QTD];
            txd_out_r <= out_data[QTD];
        end
    end

    assign o_host_rdata = rdata_r;
    assign o_host_ack = ack_r;
    assign o_txd_valid = txd_vld_r;
    assign o_txd_data = txd_out_r;
    assign o_exempt_cfg = exempt_r;
    assign o_rxs_ready = in_ready[QRS];
    assign o_rxd_ready = in_ready[QRD];
    assign o_txs_ready = in_ready[QTS];

    // Named step of a receive status peek
    sequence s_rs_peek;
        i_host_rd && (i_host_addr == HFP_RXS_PEEK) && !i_rxs_valid && !rd_rs_pop;
    endsequence

    AST_RS_PEEK_KEEP: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (s_rs_peek and !i_soft_rst) |=> (count[QRS] == $past(count[QRS])))
        else $error("peek changed receive status count");
    AST_RS_POP: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (rd_rs_pop && out_valid[QRS] && !in_valid[QRS] && !i_soft_rst)
            |=> (count[QRS] == $past(count[QRS]) - 3'h1))
        else $error("status pop did not remove head");
    AST_RD_POP: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (rd_rxd && out_valid[QRD] && !in_valid[QRD] && !i_soft_rst)
            |=> (count[QRD] == $past(count[QRD]) - 3'h1))
        else $error("receive data read did not advance");
    AST_TS_POP: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (rd_ts_pop && out_valid[QTS] && !in_valid[QTS] && !i_soft_rst)
            |=> (count[QTS] == $past(count[QTS]) - 3'h1))
        else $error("transmit status pop lost");
    AST_WO_ZERO: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_host_rd && (i_host_addr == HFP_WO_ADDR)) |=> (o_host_rdata == HFP_ZERO))
        else $error("write-only read not zero");
    AST_RX_WR_DROP: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_host_wr && (hit_rxd || i_host_addr == HFP_TXS_POP) && !i_rxd_valid
            && !rd_rxd && !i_soft_rst) |=> (count[QRD] == $past(count[QRD])))
        else $error("write reached a receive queue");
    AST_TD_PUSH: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (wr_txd && in_ready[QTD] && !out_ready[QTD] && !i_soft_rst)
            |=> (count[QTD] == $past(count[QTD]) + 3'h1))
        else $error("transmit data write lost");
    AST_SOFT_DEF: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        i_soft_rst |=> (lim_rs_r == HFP_LIM_RST) && (count[QRS] == 3'h0))
        else $error("soft reset left a default unloaded");
    AST_EXEMPT: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_soft_rst && !wr_cfg) |=> (exempt_r == $past(exempt_r)))
        else $error("exempt bits lost on soft reset");

    // Transmit status peek and latch-word write, as named steps
    sequence s_ts_peek;
        i_host_rd && (i_host_addr == HFP_TXS_PEEK) && !i_txs_valid;
    endsequence

    sequence s_lat_wr;
        i_host_wr && (i_host_addr == HFP_LAT_ADDR) && !i_hi_cond && i_lo_cond;
    endsequence

    AST_TS_PEEK_KEEP: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (s_ts_peek and !i_soft_rst) |=> (count[QTS] == $past(count[QTS])))
        else $error("peek changed transmit status count");
    AST_TS_PEEK_DATA: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (s_ts_peek and out_valid[QTS]) |=> (o_host_rdata == $past(out_data[QTS])))
        else $error("transmit status peek gave a stale word");
    AST_RS_PEEK_DATA: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_host_rd && (i_host_addr == HFP_RXS_PEEK) && out_valid[QRS])
            |=> (o_host_rdata == $past(out_data[QRS])))
        else $error("receive status peek gave a stale word");
    AST_RD_ALIAS: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (rd_rxd && out_valid[QRD]) |=> (o_host_rdata == $past(out_data[QRD])))
        else $error("receive data alias missed the head");
    AST_TD_NO_READ: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_host_rd && hit_txd) |=> (o_host_rdata == HFP_ZERO))
        else $error("transmit data read returned data");
    AST_LAT_RO: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (s_lat_wr and !i_soft_rst) |=> (lh_bit == $past(lh_bit)) && (ll_bit == $past(ll_bit)))
        else $error("write changed a read-only latch bit");

    // A host write must never move the receive data head
    AST_RX_WR_DATA: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_host_wr && hit_rxd && out_valid[QRD] && !i_soft_rst)
            |=> (out_data[QRD] == $past(out_data[QRD])))
        else $error("write moved the receive data head");
    AST_TS_WR_DROP: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_host_wr && ((i_host_addr == HFP_TXS_POP) || (i_host_addr == HFP_TXS_PEEK))
            && !i_txs_valid && !i_soft_rst) |=> (count[QTS] == $past(count[QTS])))
        else $error("write reached the transmit status queue");
endmodule
`default_nettype wire

/* File: include/hfp_pkg.sv */
/*
 Package for the host FIFO port block: port word offsets, access codes,
 queue geometry and reset values. Assumes a 32-bit host data path and
 byte addressing on an SRAM-like bus, word aligned.
*/
package hfp_pkg;
    localparam int HFP_DW = 32;
    localparam int HFP_AW = 8;
    localparam int HFP_QDEPTH = 4;
    localparam int HFP_QPW = 3;
    // Port byte addresses; data ports alias over 16 words each
    localparam logic [7:0] HFP_RXD_BASE = 8'h00;
    localparam logic [7:0] HFP_TXD_BASE = 8'h40;
    localparam logic [7:0] HFP_RXS_POP = 8'h80;
    localparam logic [7:0] HFP_RXS_PEEK = 8'h84;
    localparam logic [7:0] HFP_TXS_POP = 8'h88;
    localparam logic [7:0] HFP_TXS_PEEK = 8'h8c;
    localparam logic [7:0] HFP_STS_ADDR = 8'h90;
    localparam logic [7:0] HFP_CLR_ADDR = 8'h94;
    localparam logic [7:0] HFP_CFG_ADDR = 8'h98;
    localparam logic [7:0] HFP_WO_ADDR = 8'h9c;
    localparam logic [7:0] HFP_LAT_ADDR = 8'ha0;
    localparam int HFP_ALIAS_SHIFT = 6;
    localparam logic [1:0] HFP_RXD_TAG = 2'h0;
    localparam logic [1:0] HFP_TXD_TAG = 2'h1;
    // Field positions
    localparam int HFP_LIM_LSB = 0;
    localparam int HFP_LIM_W = 3;
    // Reset values
    localparam logic [HFP_LIM_W-1:0] HFP_LIM_RST = 3'h4;
    localparam logic [7:0] HFP_EXEMPT_RST = 8'h00;
    localparam logic [31:0] HFP_ZERO = 32'h0000_0000;
endpackage

/* File: rtl/hfp_fifo.sv */
/*
 Small flip-flop FIFO with valid/ready on both sides, and a settable
 capacity limit at or below the structural depth. Assumes one clock and a
 synchronous active-low reset; a flush input empties it.
*/
`timescale 1ns/1ps
`default_nettype none
module hfp_fifo
    import hfp_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
)
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_flush,
    input wire logic [HFP_QPW-1:0] i_limit,
    // Fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // Drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready,
    output logic [HFP_QPW-1:0] o_count
);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [1:0] wp_r;
    logic [1:0] rp_r;
    logic [HFP_QPW-1:0] cnt_r;
    logic [HFP_QPW-1:0] cap;
    logic push;
    logic pop;

    // Capacity clamps at the structural depth, never below one
    always_comb
    begin
        cap = i_limit;
        if (i_limit > HFP_QPW'(DEPTH))
            cap = HFP_QPW'(DEPTH);
        if (i_limit == '0)
            cap = 3'h1;
    end

    assign o_in_ready = (cnt_r < cap);
    assign o_out_valid = (cnt_r != '0);
    assign o_out_data = mem_r[rp_r];
    assign o_count = cnt_r;
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Storage, written by index
    always_ff @(posedge i_sys_clk)
    begin
        if (push)
            mem_r[wp_r] <= i_in_data;
    end

    // Pointers and count
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n || i_flush)
        begin
            wp_r <= 2'h0;
            rp_r <= 2'h0;
            cnt_r <= 3'h0;
        end
        else
        begin
            if (push)
                wp_r <= wp_r + 2'h1;
            if (pop)
                rp_r <= rp_r + 2'h1;
            cnt_r <= cnt_r + HFP_QPW'(push) - HFP_QPW'(pop);
        end
    end
endmodule
`default_nettype wire

/* File: rtl/hfp_attr_bits.sv */
/*
 Status bits with the documented access attributes: write-one-clear,
 clear-on-read, latch-high and latch-low. Assumes events arrive as
 levels synchronous to the clock; reads and writes are one-cycle strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module hfp_attr_bits
    import hfp_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_soft_rst,
    // Events
    input wire logic [1:0] i_w1c_evt,
    input wire logic [1:0] i_rc_evt,
    input wire logic i_hi_cond,
    input wire logic i_lo_cond,
    // Host strobes
    input wire logic i_clr_wr,
    input wire logic [1:0] i_clr_data,
    input wire logic i_sts_rd,
    input wire logic i_lat_rd,
    // Bit values
    output logic [1:0] o_w1c,
    output logic [1:0] o_rc,
    output logic o_lh,
    output logic o_ll
);
    logic [1:0] w1c_r;
    logic [1:0] rc_r;
    logic lh_r;
    logic ll_r;

    assign o_w1c = w1c_r;
    assign o_rc = rc_r;
    assign o_lh = lh_r;
    assign o_ll = ll_r;

    // Write-one-clear bits; an event in the clear cycle wins
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_bits
            always_ff @(posedge i_sys_clk)
            begin
                if (!i_reset_n || i_soft_rst)
                    w1c_r[g] <= 1'b0;
                else if (i_w1c_evt[g])
                    w1c_r[g] <= 1'b1;
                else if (i_clr_wr && i_clr_data[g])
                    w1c_r[g] <= 1'b0;
            end

            // Clear-on-read bits
            always_ff @(posedge i_sys_clk)
            begin
                if (!i_reset_n || i_soft_rst)
                    rc_r[g] <= 1'b0;
                else if (i_rc_evt[g])
                    rc_r[g] <= 1'b1;
                else if (i_sts_rd)
                    rc_r[g] <= 1'b0;
            end
        end
    endgenerate

    // Latched bits hold until their register is read
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n || i_soft_rst)
        begin
            lh_r <= 1'b0;
            ll_r <= 1'b1;
        end
        else
        begin
            if (i_hi_cond)
                lh_r <= 1'b1;
            else if (i_lat_rd)
                lh_r <= 1'b0;
            if (!i_lo_cond)
                ll_r <= 1'b0;
            else if (i_lat_rd)
                ll_r <= 1'b1;
        end
    end

    AST_W1C_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_clr_wr && !i_clr_data[0] && !i_soft_rst) |=> (w1c_r[0] == $past(w1c_r[0]))
            || w1c_r[0])
        else $error("write of zero changed a clear bit");
endmodule
`default_nettype wire

/* File: test/hfp_mac_model.sv */
/*
 Behavioural MAC-side partner: fills the receive and transmit status
 queues and drains transmit data with random stalls. Assumes the bench
 shares the clock and calls push only just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module hfp_mac_model
    import hfp_pkg::*;
(
    // Clock
    input wire logic i_sys_clk,
    // Fill sides: receive status, receive data, transmit status
    output logic o_rxs_valid,
    output logic [HFP_DW-1:0] o_rxs_data,
    input wire logic i_rxs_ready,
    output logic o_rxd_valid,
    output logic [HFP_DW-1:0] o_rxd_data,
    input wire logic i_rxd_ready,
    output logic o_txs_valid,
    output logic [HFP_DW-1:0] o_txs_data,
    input wire logic i_txs_ready,
    // Transmit data drain
    input wire logic i_txd_valid,
    input wire logic [HFP_DW-1:0] i_txd_data,
    output logic o_txd_ready
);
    logic v[3] = '{1'b0, 1'b0, 1'b0};
    logic [HFP_DW-1:0] dq[3] = '{32'h0, 32'h0, 32'h0};
    logic [2:0] rdy;
    logic [HFP_DW-1:0] txq[$];
    initial o_txd_ready = 1'b0;
    // Fan the three fill channels out to their ports
    assign o_rxs_valid = v[0];
    assign o_rxs_data = dq[0];
    assign o_rxd_valid = v[1];
    assign o_rxd_data = dq[1];
    assign o_txs_valid = v[2];
    assign o_txs_data = dq[2];
    assign rdy = {i_txs_ready, i_rxd_ready, i_rxs_ready};
    // Hold until accepted; idle data shows the inverse so stale words never match
    task automatic push(input int s, input logic [HFP_DW-1:0] d);
        v[s] = 1'b1;
        dq[s] = d;
        while (!rdy[s])
        begin
            @(posedge i_sys_clk) #1;
        end
        @(posedge i_sys_clk) #1;
        v[s] = 1'b0;
        dq[s] = ~d;
        // One idle edge, so a following push never re-raises valid in this step
        @(posedge i_sys_clk) #1;
    endtask
    // Drain with random stalls
    always @(posedge i_sys_clk)
    begin
        if (i_txd_valid === 1'b1 && o_txd_ready === 1'b1)
            txq.push_back(i_txd_data);
        #1 o_txd_ready = 1'($urandom_range(1));
    end
endmodule
`default_nettype wire

/* File: test/test_host_fifo_ports_and_access_rules.sv */
/*
 Self-checking bench for the host FIFO port block. Assumes the MAC
 partner model in its own file and the single-cycle host port answer.
*/
`timescale 1ns/1ps
`default_nettype none
module test_host_fifo_ports_and_access_rules;
    import hfp_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic soft_rst = 1'b0;
    logic host_rd = 1'b0;
    logic host_wr = 1'b0;
    logic [7:0] host_addr = 8'h00;
    logic [31:0] host_wdata = 32'h0;
    logic [31:0] host_rdata;
    logic host_ack;
    logic rxs_v, rxs_r, rxd_v, rxd_r, txs_v, txs_r, txd_v, txd_r;
    logic [31:0] rxs_d, rxd_d, txs_d, txd_d;
    logic [1:0] w1c_evt = 2'h0;
    logic [1:0] rc_evt = 2'h0;
    logic hi_cond = 1'b0;
    logic lo_cond = 1'b1;
    logic [7:0] exempt;
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [31:0] a, b, w[4], q;
    always #2 sys_clk = ~sys_clk;
    hfp_top i_dut (.i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_soft_rst(soft_rst),
        .i_host_rd(host_rd), .i_host_wr(host_wr), .i_host_addr(host_addr),
        .i_host_wdata(host_wdata), .o_host_rdata(host_rdata), .o_host_ack(host_ack),
        .i_rxs_valid(rxs_v), .i_rxs_data(rxs_d), .o_rxs_ready(rxs_r),
        .i_rxd_valid(rxd_v), .i_rxd_data(rxd_d), .o_rxd_ready(rxd_r),
        .i_txs_valid(txs_v), .i_txs_data(txs_d), .o_txs_ready(txs_r),
        .o_txd_valid(txd_v), .o_txd_data(txd_d), .i_txd_ready(txd_r),
        .i_w1c_evt(w1c_evt), .i_rc_evt(rc_evt), .i_hi_cond(hi_cond),
        .i_lo_cond(lo_cond), .o_exempt_cfg(exempt));
    hfp_mac_model i_mac (.i_sys_clk(sys_clk), .o_rxs_valid(rxs_v), .o_rxs_data(rxs_d),
        .i_rxs_ready(rxs_r), .o_rxd_valid(rxd_v), .o_rxd_data(rxd_d), .i_rxd_ready(rxd_r),
        .o_txs_valid(txs_v), .o_txs_data(txs_d), .i_txs_ready(txs_r),
        .i_txd_valid(txd_v), .i_txd_data(txd_d), .o_txd_ready(txd_r));
    // Expected configuration word from its fields
    function automatic logic [31:0] cfg_word(logic [2:0] rs, rd, td, logic [7:0] ex);
        return {8'h00, ex, 5'h00, td, 1'b0, rd, 1'b0, rs};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask
    // One host access; the answer lands one cycle after the strobe
    // Only mapped words are ever written, never a reserved one
    task automatic host(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        host_rd = ~wr;
        host_wr = wr;
        host_addr = ad;
        host_wdata = d;
        @(posedge sys_clk) #1;
        q = host_rdata;
        chk({31'h0, host_ack}, 32'h1);
        host_rd = 1'b0;
        host_wr = 1'b0;
        host_wdata = ~d;
        // Idle edge, so the next access never re-raises a strobe in this step
        @(posedge sys_clk) #1;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
        host(1'b0, ad, 32'h0);
        chk(q & m, e);
    endtask
    task automatic results;
        if (fails == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Hang guard, well above the hundred and twenty or so cycles the run needs
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            results();
        end
    end
    initial
    begin
        void'($urandom(32'h4c57));
        repeat (16) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        chk({24'h0, exempt}, 32'h0);
        rd(HFP_CFG_ADDR, 32'hffffffff, cfg_word(3'h4, 3'h4, 3'h4, 8'h00));
        rd(HFP_WO_ADDR, 32'hffffffff, 32'h0);
        rd(HFP_CLR_ADDR, 32'hffffffff, 32'h0);
        // Status queues: peek twice, pop, ignored writes to pop and peek, pop, empty pop
        for (int k = 0; k < 2; k++)
        begin
            a = $urandom;
            b = $urandom;
            i_mac.push(2 * k, a);
            i_mac.push(2 * k, b);
            rd(HFP_RXS_PEEK + 8'(8 * k), 32'hffffffff, a);
            rd(HFP_RXS_PEEK + 8'(8 * k), 32'hffffffff, a);
            rd(HFP_RXS_POP + 8'(8 * k), 32'hffffffff, a);
            host(1'b1, HFP_RXS_POP + 8'(8 * k), 32'h0);
            host(1'b1, HFP_RXS_PEEK + 8'(8 * k), 32'h0);
            rd(HFP_RXS_POP + 8'(8 * k), 32'hffffffff, b);
            rd(HFP_RXS_POP + 8'(8 * k), 32'hffffffff, 32'h0);
        end
        // Receive data: fill until refused, ignored write, drain via random aliases
        for (int i = 0; i < 4; i++)
        begin
            w[i] = $urandom;
            i_mac.push(1, w[i]);
        end
        chk({31'h0, rxd_r}, 32'h0);
        rd(HFP_STS_ADDR, 32'h700, 32'h400);
        host(1'b1, 8'h04, $urandom);
        for (int i = 0; i < 4; i++)
            rd({2'h0, 4'($urandom_range(15)), 2'h0}, 32'hffffffff, w[i]);
        rd(8'h3c, 32'hffffffff, 32'h0);
        // Transmit data through random aliases; reads give nothing
        for (int i = 0; i < 4; i++)
        begin
            w[i] = $urandom;
            host(1'b1, {2'h1, 4'($urandom_range(15)), 2'h0}, w[i]);
        end
        rd(8'h7c, 32'hffffffff, 32'h0);
        repeat (60) if (i_mac.txq.size() < 4) @(posedge sys_clk) #1;
        chk(32'(i_mac.txq.size()), 32'h4);
        for (int i = 0; i < 4 && i < i_mac.txq.size(); i++)
            chk(i_mac.txq[i], w[i]);
        // Write-one-clear, read-only status, clear-on-read, latch-high and latch-low
        w1c_evt = 2'h3;
        rc_evt = 2'h1;
        hi_cond = 1'b1;
        lo_cond = 1'b0;
        @(posedge sys_clk) #1;
        w1c_evt = 2'h0;
        rc_evt = 2'h0;
        hi_cond = 1'b0;
        lo_cond = 1'b1;
        host(1'b1, HFP_CLR_ADDR, 32'h1);
        host(1'b1, HFP_STS_ADDR, 32'h0);
        host(1'b1, HFP_LAT_ADDR, 32'h0);
        rd(HFP_STS_ADDR, 32'hf, 32'h6);
        rd(HFP_STS_ADDR, 32'hf, 32'h2);
        rd(HFP_LAT_ADDR, 32'h3, 32'h1);
        rd(HFP_LAT_ADDR, 32'h3, 32'h2);
        // Soft reset keeps the exempt byte, restores limits, flushes queues
        host(1'b1, HFP_CFG_ADDR, cfg_word(3'h2, 3'h4, 3'h4, 8'ha5));
        i_mac.push(0, $urandom);
        i_mac.push(0, $urandom);
        chk({31'h0, rxs_r}, 32'h0);
        soft_rst = 1'b1;
        @(posedge sys_clk) #1;
        soft_rst = 1'b0;
        chk({24'h0, exempt}, 32'ha5);
        chk({31'h0, rxs_r}, 32'h1);
        rd(HFP_CFG_ADDR, 32'hffffffff, cfg_word(3'h4, 3'h4, 3'h4, 8'ha5));
        rd(HFP_RXS_POP, 32'hffffffff, 32'h0);
        results();
    end
endmodule
`default_nettype wire
